// >>> cosf_selector.sv
// Contact output selector: three relay contact drivers, each with a
// chosen status function and a contact polarity, plus a change interrupt.
// Assumes status inputs and bus signals are synchronous to CLK_I.
`timescale 1ns/1ps

// How it works
// - Three independent contact outputs, each closed or open per its assigned condition.
// - Reset: output 1 run open-type, 2 remote open-type, 3 alarm closed-type.
// - Function and polarity per output are writable; closed-type is the inverse.
// - No-output function: open-type stays open, closed-type stays closed.
// - Run function: contact follows product operating, inverted for closed-type.
// - Remote function: closes in contact remote mode; closed-type closes in local.
// - Temperature-ready function: closes once fluid temperature is ready.
// - Stopping-alarm function: closes while an operation-stopping alarm is active.
// - Continuing-alarm function: closes while a continuing alarm is active.
// - Any-alarm function: closes while any alarm is active.
// - Selected-alarm function: closes only when the configured alarm is raised.
// - Start-timer function: closes while the run timer is set.
// - Stop-timer function: closes while the stop timer is set.
// - Power-recovery function: closes while automatic restart is enabled.
// - Anti-freeze function: closes while anti-freezing protection is enabled.
// - First-input pass-through mirrors contact input 1, regardless of filling option.
// - Second-input pass-through mirrors contact input 2; closed-type closes when off.
// - Auto-fill function: closes during automatic filling, option or not.
module cosf_selector
  import cosf_pkg::*;
(
  // Clock and reset
  input  wire logic                  CLK_I,
  input  wire logic                  RST_B_I,
  // Register port
  input  wire logic [ADDR_W-1:0]     REG_ADDR_I,
  input  wire logic [DATA_W-1:0]     REG_WDATA_I,
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  output logic      [DATA_W-1:0]     REG_RDATA_O,
  // Product status
  input  wire cosf_flags_type        STATUS_I,
  input  wire logic [ALM_W-1:0]      ALARM_VEC_I,
  // Contacts, high means closed
  output logic      [NUM_OUT-1:0]    CONTACT_O,
  // Interrupt
  output logic                       IRQ_O
);

  cosf_state_type     s_reg;
  cosf_state_type     s_next;
  logic [NUM_OUT-1:0] contact;
  logic [NUM_OUT-1:0] evt;
  logic [NUM_OUT-1:0] clr;

  // ----------------------------------------------------------------
  // Contact evaluation
  // ----------------------------------------------------------------
  function automatic logic eval_contact(input cosf_cfg_type     cfg,
                                        input cosf_flags_type   fl,
                                        input logic [ALM_W-1:0] av,
                                        input logic [SEL_W-1:0] sel);
    logic raw;
    raw = 1'b0;
    case (cfg.func)
      no_output_func:        raw = 1'b0;
      run_status_func:       raw = fl.running;
      remote_status_func:    raw = fl.contact_remote_mode;
      temp_ready_func:       raw = fl.temp_ready;
      stopping_alarm_func:   raw = fl.stopping_alarm;
      continuing_alarm_func: raw = fl.continuing_alarm;
      any_alarm_func:        raw = (|av) | fl.stopping_alarm | fl.continuing_alarm;
      selected_alarm_func:   raw = av[sel];
      start_timer_func:      raw = fl.start_timer_set;
      stop_timer_func:       raw = fl.stop_timer_set;
      power_recovery_func:   raw = fl.power_recovery_on;
      anti_freeze_func:      raw = fl.anti_freeze_on;
      first_input_passthru:  raw = fl.contact_in1;
      second_input_passthru: raw = fl.contact_in2;
      auto_fill_func:        raw = fl.auto_filling;
      default:               raw = 1'b0;
    endcase
    return raw ^ cfg.nc;
  endfunction

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  // one contact per output
  always_comb
  begin
    for (int i = 0; i < NUM_OUT; i++)
    begin
      contact[i] = eval_contact(s_reg.cfg[i], s_reg.flags, s_reg.alm_vec, s_reg.alm_sel);
    end
  end

  assign CONTACT_O   = contact;
  assign REG_RDATA_O = s_reg.rdata;
  assign IRQ_O       = |(s_reg.irq_stat & s_reg.irq_mask);
  assign evt         = contact ^ s_reg.prev;
  assign clr         = (REG_WR_I && REG_ADDR_I == OFS_IRQ_STAT)
                       ? REG_WDATA_I[NUM_OUT-1:0] : '0;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next         = s_reg;
    s_next.flags   = STATUS_I;
    s_next.alm_vec = ALARM_VEC_I;
    s_next.prev    = contact;
    s_next.rdata   = '0;
    if (REG_WR_I)
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        if (REG_ADDR_I == OFS_CFG_BASE + ADDR_W'(4 * i))
        begin
          s_next.cfg[i].func =
            cosf_func_type'(REG_WDATA_I[CFG_FUNC_LSB +: CFG_FUNC_W]);
          s_next.cfg[i].nc   = REG_WDATA_I[CFG_NC_BIT];
        end
      end
      if (REG_ADDR_I == OFS_ALM_SEL)
      begin
        s_next.alm_sel = REG_WDATA_I[SEL_W-1:0];
      end
      if (REG_ADDR_I == OFS_IRQ_MASK)
      begin
        s_next.irq_mask = REG_WDATA_I[NUM_OUT-1:0];
      end
    end
    // A change in the same cycle as a clear is kept
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | evt;
    if (REG_RD_I)
    begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
        if (REG_ADDR_I == OFS_CFG_BASE + ADDR_W'(4 * i))
        begin
          // Bus layout puts polarity above the function code, unlike the struct
          s_next.rdata = DATA_W'({s_reg.cfg[i].nc, s_reg.cfg[i].func});
        end
      end
      case (REG_ADDR_I)
        OFS_ALM_SEL:  s_next.rdata = DATA_W'(s_reg.alm_sel);
        OFS_CONTACT:  s_next.rdata = DATA_W'(contact);
        OFS_FLAGS:    s_next.rdata = DATA_W'(s_reg.flags);
        OFS_IRQ_STAT: s_next.rdata = DATA_W'(s_reg.irq_stat);
        OFS_IRQ_MASK: s_next.rdata = DATA_W'(s_reg.irq_mask);
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
    begin
      s_reg.cfg[0]   <= RST_CFG0;
      s_reg.cfg[1]   <= RST_CFG1;
      s_reg.cfg[2]   <= RST_CFG2;
      s_reg.alm_sel  <= RST_ALM_SEL;
      s_reg.flags    <= '0;
      s_reg.alm_vec  <= '0;
      // Matches the contacts that the reset values produce, so no event
      s_reg.prev     <= RST_CONTACT;
      s_reg.irq_stat <= '0;
      s_reg.irq_mask <= RST_IRQ_MASK;
      s_reg.rdata    <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // flags one cycle behind the inputs
  a_flags_sampled: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    ##1 s_reg.flags == $past(STATUS_I))
    else $error("registered flags do not follow status inputs");

  a_reset_default: assert property (
    @(posedge CLK_I) $rose(RST_B_I) |-> CONTACT_O == RST_CONTACT)
    else $error("contacts after reset differ from the default");

  a_cfg_write: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_WR_I && REG_ADDR_I == OFS_CFG_BASE
    |=> s_reg.cfg[0].nc == $past(REG_WDATA_I[CFG_NC_BIT]))
    else $error("configuration write not stored");

  for (genvar gi = 0; gi < NUM_OUT; gi++)
  begin : g_chk
    a_none_fixed: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == no_output_func |-> CONTACT_O[gi] == s_reg.cfg[gi].nc)
      else $error("no-output contact not at its rest state");

    a_run_follow: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == run_status_func && $stable(s_reg.cfg[gi])
      |-> CONTACT_O[gi] == ($past(STATUS_I.running) ^ s_reg.cfg[gi].nc))
      else $error("run contact does not follow operation");

    a_any_alarm: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == any_alarm_func && $past(ALARM_VEC_I) != '0
      |-> CONTACT_O[gi] == !s_reg.cfg[gi].nc)
      else $error("any-alarm contact not active with alarm raised");

    a_sel_alarm: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == selected_alarm_func && $stable(s_reg.alm_sel)
      |-> CONTACT_O[gi] == ($past(ALARM_VEC_I[s_reg.alm_sel]) ^ s_reg.cfg[gi].nc))
      else $error("selected-alarm contact wrong");

    a_in2_mirror: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == second_input_passthru && s_reg.cfg[gi].nc
      && !s_reg.flags.contact_in2 |-> CONTACT_O[gi])
      else $error("closed-type input 2 mirror not closed with input off");

    a_change_flag: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      $changed(CONTACT_O[gi]) |=> s_reg.irq_stat[gi])
      else $error("contact change not flagged");

    a_remote_follow: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == remote_status_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.contact_remote_mode) ^ s_reg.cfg[gi].nc))
      else $error("remote contact does not follow remote mode");

    a_ready_follow: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == temp_ready_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.temp_ready) ^ s_reg.cfg[gi].nc))
      else $error("ready contact does not follow temperature ready");

    a_stop_alarm: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == stopping_alarm_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.stopping_alarm) ^ s_reg.cfg[gi].nc))
      else $error("stopping-alarm contact wrong");

    a_cont_alarm: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == continuing_alarm_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.continuing_alarm) ^ s_reg.cfg[gi].nc))
      else $error("continuing-alarm contact wrong");

    a_start_timer: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == start_timer_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.start_timer_set) ^ s_reg.cfg[gi].nc))
      else $error("start-timer contact wrong");

    a_stop_timer: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == stop_timer_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.stop_timer_set) ^ s_reg.cfg[gi].nc))
      else $error("stop-timer contact wrong");

    a_recovery_follow: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == power_recovery_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.power_recovery_on) ^ s_reg.cfg[gi].nc))
      else $error("power-recovery contact wrong");

    a_freeze_follow: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == anti_freeze_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.anti_freeze_on) ^ s_reg.cfg[gi].nc))
      else $error("anti-freeze contact wrong");

    a_in1_mirror: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == first_input_passthru
      |-> CONTACT_O[gi] == ($past(STATUS_I.contact_in1) ^ s_reg.cfg[gi].nc))
      else $error("input 1 mirror contact wrong");

    a_fill_follow: assert property (
      @(posedge CLK_I) disable iff (!RST_B_I)
      s_reg.cfg[gi].func == auto_fill_func
      |-> CONTACT_O[gi] == ($past(STATUS_I.auto_filling) ^ s_reg.cfg[gi].nc))
      else $error("auto-fill contact wrong");
  end

  a_irq_level: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    $past(REG_WR_I && REG_ADDR_I == OFS_IRQ_MASK && REG_WDATA_I[NUM_OUT-1:0] == '0)
    |-> !IRQ_O)
    else $error("interrupt still high after a zero mask write");

  a_read_contact: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_RD_I && REG_ADDR_I == OFS_CONTACT
    |=> REG_RDATA_O == DATA_W'($past(CONTACT_O)))
    else $error("contact read back wrong");


  // read data only in the cycle after a read
  a_rdata_idle: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    !REG_RD_I |=> REG_RDATA_O == '0)
    else $error("read data not zero outside a read answer");

  a_func_write: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_WR_I && REG_ADDR_I == OFS_CFG_BASE
    |=> s_reg.cfg[0].func == $past(REG_WDATA_I[CFG_FUNC_LSB +: CFG_FUNC_W]))
    else $error("function code write not stored");

  // polarity read back in its field
  a_read_cfg_nc: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_RD_I && REG_ADDR_I == OFS_CFG_BASE
    |=> REG_RDATA_O[CFG_NC_BIT] == $past(s_reg.cfg[0].nc))
    else $error("polarity read back in the wrong field");

  a_sel_write: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_WR_I && REG_ADDR_I == OFS_ALM_SEL
    |=> s_reg.alm_sel == $past(REG_WDATA_I[SEL_W-1:0]))
    else $error("alarm select write not stored");

  a_mask_write: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_WR_I && REG_ADDR_I == OFS_IRQ_MASK
    |=> s_reg.irq_mask == $past(REG_WDATA_I[NUM_OUT-1:0]))
    else $error("interrupt mask write not stored");

  // write of ones clears quiet status
  a_stat_clear: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    REG_WR_I && REG_ADDR_I == OFS_IRQ_STAT && REG_WDATA_I[NUM_OUT-1:0] == '1
    && !$changed(CONTACT_O) |=> s_reg.irq_stat == '0)
    else $error("status bits not cleared by a write of ones");

endmodule // cosf_selector

// >>> cosf_pkg.sv
// Shared constants and types for the contact output selector.
// Assumes a 32-bit plain register port and a synchronous status source.
package cosf_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 3;
  localparam int ALM_W   = 16;
  localparam int SEL_W   = 4;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CFG_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ALM_SEL  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CONTACT  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1C;

  // ----------------------------------------------------------------
  // Field positions of an output configuration word
  // ----------------------------------------------------------------
  localparam int CFG_FUNC_LSB = 0;
  localparam int CFG_FUNC_W   = 4;
  localparam int CFG_NC_BIT   = 4;

  // ----------------------------------------------------------------
  // Output functions
  // ----------------------------------------------------------------
  typedef enum logic [CFG_FUNC_W-1:0] {
    no_output_func,
    run_status_func,
    remote_status_func,
    temp_ready_func,
    stopping_alarm_func,
    continuing_alarm_func,
    any_alarm_func,
    selected_alarm_func,
    start_timer_func,
    stop_timer_func,
    power_recovery_func,
    anti_freeze_func,
    first_input_passthru,
    second_input_passthru,
    auto_fill_func
  } cosf_func_type;

  typedef struct packed {
    cosf_func_type func;
    logic          nc;
  } cosf_cfg_type;

  typedef struct packed {
    logic running;
    logic contact_remote_mode;
    logic temp_ready;
    logic stopping_alarm;
    logic continuing_alarm;
    logic start_timer_set;
    logic stop_timer_set;
    logic power_recovery_on;
    logic anti_freeze_on;
    logic contact_in1;
    logic contact_in2;
    logic auto_filling;
  } cosf_flags_type;

  localparam int FLAGS_W = $bits(cosf_flags_type);

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam cosf_cfg_type RST_CFG0 = '{func: run_status_func,    nc: 1'b0};
  localparam cosf_cfg_type RST_CFG1 = '{func: remote_status_func, nc: 1'b0};
  localparam cosf_cfg_type RST_CFG2 = '{func: any_alarm_func,     nc: 1'b1};
  localparam logic [SEL_W-1:0]   RST_ALM_SEL  = 4'h0;
  localparam logic [NUM_OUT-1:0] RST_CONTACT  = 3'h4;
  localparam logic [NUM_OUT-1:0] RST_IRQ_MASK = 3'h0;

  typedef struct packed {
    cosf_cfg_type [NUM_OUT-1:0] cfg;
    logic [SEL_W-1:0]           alm_sel;
    cosf_flags_type             flags;
    logic [ALM_W-1:0]           alm_vec;
    logic [NUM_OUT-1:0]         prev;
    logic [NUM_OUT-1:0]         irq_stat;
    logic [NUM_OUT-1:0]         irq_mask;
    logic [DATA_W-1:0]          rdata;
  } cosf_state_type;

endpackage

// >>> cosf_contact_reader.sv
// Customer equipment model: samples the relay contacts once per clock.
// Assumes contacts are levels synchronous to the system clock, 1 = closed.
`timescale 1ns/1ps

module cosf_contact_reader
  import cosf_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  // Contacts seen at the terminal block
  input  wire logic [NUM_OUT-1:0]   contact_i,
  output logic      [NUM_OUT-1:0]   seen_o
);
  // ----------------------------------------------------------------
  // Sampling
  // ----------------------------------------------------------------
  // Real equipment only sees settled contacts, so it registers them
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      seen_o <= 3'h0;
    else
      seen_o <= contact_i;
  end
endmodule // cosf_contact_reader

// >>> testbench.sv
// Self-checking bench for the contact output selector.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/1ps

module testbench;
  import cosf_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic [ADDR_W-1:0]    addr = 8'h00;
  logic [DATA_W-1:0]    wdata = 32'h0;
  logic                 wr = 1'b0;
  logic                 rd = 1'b0;
  logic [DATA_W-1:0]    rdata;
  cosf_flags_type       status = '0;
  logic [ALM_W-1:0]     alarm = 16'h0;
  logic [NUM_OUT-1:0]   contact;
  logic [NUM_OUT-1:0]   seen;
  logic                 irq;
  cosf_cfg_type         cfg [NUM_OUT];
  int                   failures = 0;
  int                   n_compared = 0;
  int                   cycles = 0;
  localparam int        SEL_IDX = 9;

  always #50 clk = ~clk;

  cosf_selector cosf_selector_i (
    .CLK_I(clk), .RST_B_I(rst_b), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .STATUS_I(status),
    .ALARM_VEC_I(alarm), .CONTACT_O(contact), .IRQ_O(irq));
  cosf_contact_reader cosf_contact_reader_i (
    .clk_i(clk), .rst_b_i(rst_b), .contact_i(contact), .seen_o(seen));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    check(rdata, e);
  endtask

  // Expected contact level of one output, worked out from its config
  function automatic logic exp_out(cosf_cfg_type c, logic [FLAGS_W-1:0] fl,
                                   logic [ALM_W-1:0] av);
    int  f;
    logic v;
    f = int'(c.func);
    v = 1'b0;
    if (f >= 1 && f <= 5)
      v = fl[12-f];
    else if (f == 6)
      v = (|av) | fl[8] | fl[7];
    else if (f == 7)
      v = av[SEL_IDX];
    else if (f >= 8 && f <= 14)
      v = fl[14-f];
    return v ^ c.nc;
  endfunction

  // Changes status, then looks one edge later: outputs follow registered flags
  task automatic apply(input logic [FLAGS_W-1:0] p, input logic [ALM_W-1:0] av);
    logic [NUM_OUT-1:0] e;
    @(posedge clk);
    status <= cosf_flags_type'(p);
    alarm  <= av;
    @(posedge clk);
    #1;
    for (int o = 0; o < NUM_OUT; o++)
      e[o] = exp_out(cfg[o], p, av);
    check({29'h0, contact}, {29'h0, e});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_defaults();
    reg_rd(OFS_CFG_BASE, 32'h01);
    reg_rd(8'h04, 32'h02);
    reg_rd(8'h08, 32'h16);
    reg_rd(OFS_CONTACT, 32'h4);
    reg_rd(OFS_IRQ_MASK, 32'h0);
    reg_wr(8'h40, 32'h1F);
    reg_rd(8'h40, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask

  // Every function and polarity on every output, target flag alone and inverted
  task automatic test_functions();
    logic [FLAGS_W-1:0] tp;
    logic [ALM_W-1:0]   tav;
    logic [3:0]         fv;
    reg_wr(OFS_ALM_SEL, SEL_IDX);
    reg_rd(OFS_ALM_SEL, SEL_IDX);
    for (int o = 0; o < NUM_OUT; o++)
      for (int f = 0; f < 15; f++)
        for (int nc = 0; nc < 2; nc++)
        begin
          fv = f[3:0];
          cfg[o] = '{func: cosf_func_type'(fv), nc: nc[0]};
          reg_wr(ADDR_W'(o * 4), {27'h0, nc[0], fv});
          reg_rd(ADDR_W'(o * 4), {27'h0, nc[0], fv});
          tp  = 12'h0;
          tav = 16'h0;
          if (f >= 1 && f <= 5)
            tp = 12'h1 << (12 - f);
          else if (f >= 8)
            tp = 12'h1 << (14 - f);
          else if (f == 6 || f == 7)
            tav = 16'h1 << SEL_IDX;
          apply(tp, tav);
          apply(~tp, ~tav);
        end
  endtask

  task automatic test_irq();
    cfg[0] = '{func: run_status_func, nc: 1'b0};
    reg_wr(OFS_CFG_BASE, 32'h01);
    apply(12'h0, 16'h0);
    reg_wr(OFS_IRQ_STAT, 32'h7);
    reg_wr(OFS_IRQ_MASK, 32'h1);
    reg_rd(OFS_IRQ_STAT, 32'h0);
    apply(12'h800, 16'h0);
    @(posedge clk);
    #1;
    check({31'h0, irq}, 32'h1);
    // Outputs 2 and 3 are closed-type auto-fill with filling off, so closed
    check({29'h0, seen}, 32'h7);
    reg_rd(OFS_FLAGS, 32'h800);
    reg_rd(OFS_IRQ_STAT, 32'h1);
    reg_wr(OFS_IRQ_MASK, 32'h0);
    #1;
    check({31'h0, irq}, 32'h0);
    reg_wr(OFS_IRQ_MASK, 32'h1);
    reg_wr(OFS_IRQ_STAT, 32'h1);
    #1;
    check({31'h0, irq}, 32'h0);
    reg_rd(OFS_IRQ_STAT, 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    cfg[0] = RST_CFG0;
    cfg[1] = RST_CFG1;
    cfg[2] = RST_CFG2;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    test_defaults();
    test_functions();
    test_irq();
    conclude();
  end
endmodule // testbench
